// ---- core/limit_sync.sv ----
// Two-stage synchroniser with polarity decode for one limit input.
`timescale 1ns/1ns
module limit_sync
	import move_param_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic [1:0] setting,
	output logic hit
);

	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
		end
	end

	// A low pin level means the circuit is energized, or closed.
	always_comb begin
		case (setting)
			LIM_CLOSED: hit = ~sync_reg;
			LIM_OPEN: hit = sync_reg;
			default: hit = 1'b0;
		endcase
	end

endmodule // limit_sync

// ---- core/move_param_limit_logic.sv ----
// Move parameter store and end-of-travel limit handling for a motor drive.
// Behaviour
// - Change distance stored as magnitude; its sign is dropped.
// - Moves using change distance switch behaviour once travel reaches it.
// - Masked sensor feed ignores sensor until change distance is travelled.
// - Deceleration accepts 0.167 to 5461.067 rps/s in 0.167 steps.
// - Stored deceleration is used at end of point-to-point moves.
// - Positive move distance means clockwise, negative counter-clockwise.
// - Move distance is signed, magnitude up to 2,147,483,647.
// - Move distance is relative travel or absolute target.
// - Move distance sign selects the jog direction.
// - Active limit stops motion in its direction and raises an alarm.
// - Both limits share one setting: low, high or unused.
// - Setting 1: limit when input closed; stop at max acceleration.
// - Setting 2: limit when input open; stop at max acceleration.
// - Setting 3 disables limits; only 1, 2, 3 accepted.
// - Limit setting ignored in control mode 7 or 11 to 18.
// - Pulse input is clockwise limit, direction input counter-clockwise.
// - Jog assignment after limit setting takes the inputs, forces setting 3.
// - Control mode ownership overrides; limit and jog assignments: last wins.
// - Energized input reads low (closed); de-energized reads high (open).
`timescale 1ns/1ns
module move_param_limit_logic
	import move_param_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire host_cmd_t cmd,
	output host_reply_t reply,
	output logic cmd_reject,
	input wire nv_image_t nv_load,
	output nv_image_t nv_store,
	output logic nv_write,
	input wire logic [MODE_W-1:0] operating_profile_select,
	input wire logic step_pin,
	input wire logic dir_pin,
	input wire logic move_start,
	input wire move_kind_t move_kind,
	input wire logic move_active,
	input wire logic [DIST_W-1:0] travelled,
	input wire logic sensor_in,
	output move_setup_t setup,
	output logic change_reached,
	output logic sensor_enabled,
	output logic cw_inhibit,
	output logic ccw_inhibit,
	output logic stop_max_accel,
	output logic limit_alarm,
	output logic jog_inputs_owned,
	output logic limit_inputs_owned,
	output logic [1:0] gp_inputs
);

	logic rst_meta_reg;
	logic rst_n;
	logic [DIST_W-1:0] chg_reg;
	logic [DECEL_W-1:0] decel_reg;
	logic [DIST_W-1:0] move_reg;
	logic [1:0] limit_reg;
	logic loaded_reg;
	logic mode_owns;
	logic [1:0] eff_limit;
	logic cw_hit;
	logic ccw_hit;
	logic [DIST_W-1:0] abs_val;
	logic value_ok;
	logic cmd_wr;
	logic [DIST_W-1:0] move_mag;
	logic step_meta_reg;
	logic step_sync_reg;
	logic dir_meta_reg;
	logic dir_sync_reg;
	logic sensor_meta_reg;
	logic sensor_sync_reg;

	// Reset is asserted at once but released two edges late, so that every
	// flop of the block leaves reset on one clean edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// Magnitude of the incoming value, used by the change distance and by the
	// range check of the move distance.
	always_comb begin
		if (cmd.value[DIST_W-1]) begin
			abs_val = DIST_W'(-cmd.value);
		end else begin
			abs_val = cmd.value;
		end
	end

	// Range check per parameter on a write.
	always_comb begin
		case (cmd.sel)
			SEL_CHG: value_ok = 1'b1;
			SEL_DECEL: begin
				value_ok = (cmd.value >= 32'(DECEL_MIN))
					&& (cmd.value <= 32'(DECEL_MAX));
			end
			SEL_MOVE: value_ok = (abs_val <= DIST_MAX);
			SEL_LIMIT: begin
				value_ok = (cmd.value == 32'(LIM_CLOSED))
					|| (cmd.value == 32'(LIM_OPEN))
					|| (cmd.value == 32'(LIM_OFF));
			end
			SEL_JOG: value_ok = 1'b1;
			default: value_ok = 1'b0;
		endcase
	end

	assign cmd_wr = cmd.valid && cmd.write && value_ok;

	// Modes 7 and 11 to 18 own the shared pulse and direction inputs.
	assign mode_owns = (operating_profile_select == MODE_PULSE)
		|| ((operating_profile_select >= MODE_OWN_LO)
		&& (operating_profile_select <= MODE_OWN_HI));

	assign eff_limit = mode_owns ? LIM_OFF : limit_reg;

	// Settings restore once after reset from the non-volatile image.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_reg <= CHG_RST;
		end else if (!loaded_reg) begin
			chg_reg <= nv_load.valid ? nv_load.chg : CHG_RST;
		end else if (cmd_wr && cmd.sel == SEL_CHG) begin
			chg_reg <= abs_val;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decel_reg <= DECEL_RST;
		end else if (!loaded_reg) begin
			decel_reg <= nv_load.valid ? nv_load.decel : DECEL_RST;
		end else if (cmd_wr && cmd.sel == SEL_DECEL) begin
			decel_reg <= cmd.value[DECEL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			move_reg <= MOVE_RST;
		end else if (!loaded_reg) begin
			move_reg <= nv_load.valid ? nv_load.move : MOVE_RST;
		end else if (cmd_wr && cmd.sel == SEL_MOVE) begin
			move_reg <= cmd.value;
		end
	end

	// Limit and jog assignments overwrite each other; the last one wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_reg <= LIM_RST;
		end else if (!loaded_reg) begin
			limit_reg <= nv_load.valid ? nv_load.limit : LIM_RST;
		end else if (cmd_wr && cmd.sel == SEL_LIMIT) begin
			limit_reg <= cmd.value[1:0];
		end else if (cmd_wr && cmd.sel == SEL_JOG) begin
			limit_reg <= LIM_OFF;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_inputs_owned <= 1'b0;
		end else if (cmd_wr && cmd.sel == SEL_JOG) begin
			jog_inputs_owned <= ~mode_owns;
		end else if (cmd_wr && cmd.sel == SEL_LIMIT) begin
			jog_inputs_owned <= 1'b0;
		end else if (mode_owns) begin
			jog_inputs_owned <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_inputs_owned <= 1'b0;
		end else begin
			limit_inputs_owned <= (eff_limit != LIM_OFF);
		end
	end

	// Every accepted write after the restore cycle is copied to the non-volatile store.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nv_write <= 1'b0;
			nv_store <= '0;
		end else begin
			nv_write <= cmd_wr && loaded_reg;
			nv_store <= {1'b1, chg_reg, decel_reg, move_reg, limit_reg};
		end
	end

	// A bare command answers with its name and current value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reply <= '0;
			cmd_reject <= 1'b0;
		end else begin
			reply.valid <= cmd.valid && !cmd.write;
			reply.sel <= cmd.sel;
			case (cmd.sel)
				SEL_CHG: reply.value <= chg_reg;
				SEL_DECEL: reply.value <= 32'(decel_reg);
				SEL_MOVE: reply.value <= move_reg;
				SEL_LIMIT: reply.value <= 32'(limit_reg);
				SEL_JOG: reply.value <= 32'(jog_inputs_owned);
				default: reply.value <= '0;
			endcase
			cmd_reject <= cmd.valid && cmd.write && !value_ok;
		end
	end

	always_comb begin
		if (move_reg[DIST_W-1]) begin
			move_mag = DIST_W'(-move_reg);
		end else begin
			move_mag = move_reg;
		end
	end

	// Move setup is latched when the profile generator starts a move.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setup <= '0;
		end else if (move_start) begin
			setup.cw <= ~move_reg[DIST_W-1];
			setup.decel <= decel_reg;
			if (move_kind == MV_ABS) begin
				setup.target <= move_reg;
				setup.travel <= '0;
			end else begin
				setup.travel <= move_mag;
				setup.target <= '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sensor_meta_reg <= 1'b1;
			sensor_sync_reg <= 1'b1;
		end else begin
			sensor_meta_reg <= sensor_in;
			sensor_sync_reg <= sensor_meta_reg;
		end
	end

	// A set in the same cycle as a move start wins, so the change point is
	// never lost; the generator must restart its travel count with each
	// move, or a restarted masked feed sees its sensor at once.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			change_reached <= 1'b0;
		end else if (move_active && travelled >= chg_reg) begin
			change_reached <= 1'b1;
		end else if (move_start) begin
			change_reached <= 1'b0;
		end
	end

	// Sensor is masked in the masked feed until the change point.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sensor_enabled <= 1'b0;
		end else if (move_kind == MV_MASK_SENSOR && !change_reached) begin
			sensor_enabled <= 1'b0;
		end else begin
			sensor_enabled <= ~sensor_sync_reg;
		end
	end

	// The pulse input guards clockwise travel, the direction input the other.
	limit_sync u_cw_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(step_pin),
		.setting(eff_limit),
		.hit(cw_hit)
	);

	limit_sync u_ccw_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(dir_pin),
		.setting(eff_limit),
		.hit(ccw_hit)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cw_inhibit <= 1'b0;
			ccw_inhibit <= 1'b0;
			stop_max_accel <= 1'b0;
			limit_alarm <= 1'b0;
		end else begin
			cw_inhibit <= cw_hit;
			ccw_inhibit <= ccw_hit;
			stop_max_accel <= (cw_hit && setup.cw && move_active)
				|| (ccw_hit && !setup.cw && move_active);
			limit_alarm <= cw_hit || ccw_hit;
		end
	end

	// Synchronised pulse and direction inputs are handed on as general purpose when limits are off.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_meta_reg <= 1'b1;
			step_sync_reg <= 1'b1;
			dir_meta_reg <= 1'b1;
			dir_sync_reg <= 1'b1;
			gp_inputs <= 2'h3;
		end else begin
			step_meta_reg <= step_pin;
			step_sync_reg <= step_meta_reg;
			dir_meta_reg <= dir_pin;
			dir_sync_reg <= dir_meta_reg;
			if (eff_limit == LIM_OFF) begin
				gp_inputs <= {dir_sync_reg, step_sync_reg};
			end else begin
				gp_inputs <= 2'h3;
			end
		end
	end

endmodule // move_param_limit_logic

// ---- core/move_param_pkg.sv ----
// Package of constants and types for the move parameter and limit block.
package move_param_pkg;

	localparam int DIST_W = 32;
	localparam int DECEL_W = 15;
	localparam int MODE_W = 5;

	// Largest magnitude a move distance may hold; the change distance is not range checked.
	localparam logic [31:0] DIST_MAX = 32'h7FFFFFFF;

	// Deceleration is held in units of 0.167 rps/s; 1 to 32701 units.
	localparam logic [DECEL_W-1:0] DECEL_MIN = 15'h0001;
	localparam logic [DECEL_W-1:0] DECEL_MAX = 15'h7FBD;

	// Limit setting codes.
	localparam logic [1:0] LIM_CLOSED = 2'h1;
	localparam logic [1:0] LIM_OPEN = 2'h2;
	localparam logic [1:0] LIM_OFF = 2'h3;

	// Control modes that own the shared pulse and direction inputs.
	localparam logic [MODE_W-1:0] MODE_PULSE = 5'h07;
	localparam logic [MODE_W-1:0] MODE_OWN_LO = 5'h0B;
	localparam logic [MODE_W-1:0] MODE_OWN_HI = 5'h12;

	// Reset values used when the stored copy is invalid.
	localparam logic [31:0] CHG_RST = 32'h00000000;
	localparam logic [DECEL_W-1:0] DECEL_RST = 15'h0258;
	localparam logic [31:0] MOVE_RST = 32'h00000000;
	localparam logic [1:0] LIM_RST = 2'h3;

	// Parameter selectors of the command port.
	typedef enum logic [2:0] {
		SEL_CHG = 3'h0,
		SEL_DECEL = 3'h1,
		SEL_MOVE = 3'h2,
		SEL_LIMIT = 3'h3,
		SEL_JOG = 3'h4
	} param_sel_t;

	// Kinds of move that the profile generator may run.
	typedef enum logic [2:0] {
		MV_REL = 3'h0,
		MV_ABS = 3'h1,
		MV_SPEED_CHG = 3'h2,
		MV_MASK_SENSOR = 3'h3,
		MV_JOG = 3'h4
	} move_kind_t;

	// Decoded host command: write carries a value, a bare command queries.
	typedef struct packed {
		logic valid;
		logic write;
		param_sel_t sel;
		logic [DIST_W-1:0] value;
	} host_cmd_t;

	// Reply to a query: selector echoes the parameter name.
	typedef struct packed {
		logic valid;
		param_sel_t sel;
		logic [DIST_W-1:0] value;
	} host_reply_t;

	// Non-volatile image of the settings.
	typedef struct packed {
		logic valid;
		logic [DIST_W-1:0] chg;
		logic [DECEL_W-1:0] decel;
		logic [DIST_W-1:0] move;
		logic [1:0] limit;
	} nv_image_t;

	// Values handed to the motion profile generator at move start.
	typedef struct packed {
		logic cw;
		logic [DIST_W-1:0] travel;
		logic [DIST_W-1:0] target;
		logic [DECEL_W-1:0] decel;
	} move_setup_t;

endpackage

// ---- tb/host_model.sv ----
// Host model that issues parameter commands and collects answers.
`timescale 1ns/1ns
module host_model
	import move_param_pkg::*;
(
	input wire logic clk,
	output host_cmd_t cmd,
	input wire host_reply_t reply,
	input wire logic cmd_reject
);
	initial cmd = '0;
	// The answer is registered on the edge that takes the command, so it is read at the next falling edge.
	task automatic issue(input logic wr, input param_sel_t sel,
		input logic [31:0] val, output logic [31:0] got, output logic rej);
		@(negedge clk);
		cmd <= '{valid: 1'h1, write: wr, sel: sel, value: val};
		@(negedge clk);
		got = reply.valid ? reply.value : 32'hDEADBEEF;
		rej = cmd_reject;
		cmd.valid <= 1'h0;
		cmd.value <= ~val;
	endtask
endmodule // host_model

// ---- tb/move_param_limit_logic_chk.sv ----
// Assertions on the ports of the move parameter and limit block.
`timescale 1ns/1ns
module move_param_limit_logic_chk
	import move_param_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire host_cmd_t cmd,
	input wire host_reply_t reply,
	input wire logic cmd_reject,
	input wire nv_image_t nv_store,
	input wire logic nv_write,
	input wire logic [MODE_W-1:0] operating_profile_select,
	input wire logic move_start,
	input wire move_kind_t move_kind,
	input wire logic move_active,
	input wire move_setup_t setup,
	input wire logic change_reached,
	input wire logic sensor_enabled,
	input wire logic cw_inhibit,
	input wire logic ccw_inhibit,
	input wire logic limit_alarm
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic wr_c;
	logic owned;
	logic [31:0] mag;
	assign wr_c = cmd.valid && cmd.write;
	assign mag = cmd.value[31] ? -cmd.value : cmd.value;
	assign owned = operating_profile_select == MODE_PULSE ||
		(operating_profile_select >= MODE_OWN_LO &&
		operating_profile_select <= MODE_OWN_HI);
	sequence stored_s;
		##1 (nv_write && !cmd_reject) ##1 1'b1;
	endsequence
	sequence mask_wait_s;
		(move_active && move_kind == MV_MASK_SENSOR && !change_reached)[*2];
	endsequence
	decel_refuse_a: assert property (wr_c && cmd.sel == SEL_DECEL &&
		(cmd.value < 32'(DECEL_MIN) || cmd.value > 32'(DECEL_MAX))
		|=> cmd_reject && !nv_write)
		else $error("decel out of range not refused");
	decel_keep_a: assert property (wr_c && cmd.sel == SEL_DECEL &&
		cmd.value >= 32'(DECEL_MIN) && cmd.value <= 32'(DECEL_MAX)
		|-> stored_s ##0 nv_store.decel == $past(cmd.value[14:0], 2))
		else $error("decel not stored");
	limit_refuse_a: assert property (wr_c && cmd.sel == SEL_LIMIT &&
		(cmd.value == 32'h0 || cmd.value > 32'h3) |=> cmd_reject)
		else $error("bad limit setting accepted");
	move_refuse_a: assert property (wr_c && cmd.sel == SEL_MOVE &&
		cmd.value == 32'h80000000 |=> cmd_reject)
		else $error("move magnitude over range accepted");
	chg_mag_a: assert property (wr_c && cmd.sel == SEL_CHG &&
		cmd.value != 32'h80000000 |-> ##2 nv_store.chg == $past(mag, 2))
		else $error("change distance not stored as magnitude");
	query_echo_a: assert property (cmd.valid && !cmd.write |=>
		reply.valid && reply.sel == $past(cmd.sel))
		else $error("query not answered");
	mode_owns_a: assert property (owned[*4] |->
		!cw_inhibit && !ccw_inhibit && !limit_alarm)
		else $error("limit active in owning mode");
	setup_dir_a: assert property (move_start |=>
		setup.cw == !nv_store.move[31] && setup.decel == nv_store.decel)
		else $error("move setup direction or decel wrong");
	abs_target_a: assert property (move_start && move_kind == MV_ABS
		|=> setup.target == nv_store.move)
		else $error("absolute target wrong");
	sensor_mask_a: assert property (mask_wait_s |-> !sensor_enabled)
		else $error("sensor honoured before change distance");
endmodule // move_param_limit_logic_chk

bind move_param_limit_logic move_param_limit_logic_chk chk_inst (
	.clk(clk), .nrst(nrst), .cmd(cmd), .reply(reply),
	.cmd_reject(cmd_reject), .nv_store(nv_store), .nv_write(nv_write),
	.operating_profile_select(operating_profile_select),
	.move_start(move_start), .move_kind(move_kind),
	.move_active(move_active), .setup(setup),
	.change_reached(change_reached), .sensor_enabled(sensor_enabled),
	.cw_inhibit(cw_inhibit), .ccw_inhibit(ccw_inhibit),
	.limit_alarm(limit_alarm));

// ---- tb/test_move_param_limit_logic.sv ----
// Self-checking bench for the move parameter and limit block.
`timescale 1ns/1ns
module test_move_param_limit_logic;
	import move_param_pkg::*;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	host_cmd_t cmd;
	host_reply_t reply;
	nv_image_t nv_load;
	move_setup_t setup;
	move_kind_t move_kind;
	logic [MODE_W-1:0] mode;
	logic [31:0] travelled, got;
	logic [1:0] gp;
	logic step_pin, dir_pin, move_start, move_active, sensor_in, rej;
	logic chg_hit, sens_en, cw_inh, ccw_inh, stop_acc, alarm;
	logic jog_own, lim_own;
	logic [2:0] lim_exp [3] = '{3'h5, 3'h3, 3'h0};
	logic [4:0] modes [3] = '{5'h07, 5'h0B, 5'h12};
	int errors = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	move_param_limit_logic move_param_limit_logic_inst (.clk(clk),
		.nrst(nrst), .cmd(cmd), .reply(reply), .cmd_reject(rej),
		.nv_load(nv_load), .nv_store(), .nv_write(),
		.operating_profile_select(mode), .step_pin(step_pin),
		.dir_pin(dir_pin), .move_start(move_start), .move_kind(move_kind),
		.move_active(move_active), .travelled(travelled),
		.sensor_in(sensor_in), .setup(setup), .change_reached(chg_hit),
		.sensor_enabled(sens_en), .cw_inhibit(cw_inh),
		.ccw_inhibit(ccw_inh), .stop_max_accel(stop_acc),
		.limit_alarm(alarm), .jog_inputs_owned(jog_own),
		.limit_inputs_owned(lim_own), .gp_inputs(gp));
	host_model host_model_inst (.clk(clk), .cmd(cmd), .reply(reply),
		.cmd_reject(rej));
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input param_sel_t s, input logic [31:0] v,
		input logic er);
		logic r;
		host_model_inst.issue(1'h1, s, v, got, r);
		chk(r, er);
	endtask
	task automatic rd(input param_sel_t s, input logic [31:0] e);
		logic r;
		host_model_inst.issue(1'h0, s, 32'h0, got, r);
		chk(got, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic mv(input move_kind_t k);
		move_kind = k;
		move_start = 1'h1;
		wt(1);
		move_start = 1'h0;
		wt(1);
	endtask
	task automatic do_reset();
		nrst = 1'h0;
		wt(8);
		nrst = 1'h1;
		wt(6);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		wrap_up();
	end
	initial begin
		nv_load = '0;
		mode = 5'h00;
		step_pin = 1'h1;
		dir_pin = 1'h1;
		move_start = 1'h0;
		move_kind = MV_REL;
		move_active = 1'h0;
		travelled = 32'h0;
		sensor_in = 1'h1;
		do_reset();
		rd(SEL_CHG, CHG_RST);
		rd(SEL_DECEL, 32'(DECEL_RST));
		rd(SEL_MOVE, MOVE_RST);
		rd(SEL_LIMIT, 32'(LIM_RST));
		$display("test 1 done");
		wr(SEL_CHG, 32'hFFFFFFFB, 1'h0);
		rd(SEL_CHG, 32'h5);
		wr(SEL_CHG, DIST_MAX, 1'h0);
		rd(SEL_CHG, DIST_MAX);
		wr(SEL_DECEL, 32'h0, 1'h1);
		wr(SEL_DECEL, 32'h7FBE, 1'h1);
		wr(SEL_DECEL, 32'h1, 1'h0);
		rd(SEL_DECEL, 32'h1);
		wr(SEL_DECEL, 32'h7FBD, 1'h0);
		rd(SEL_DECEL, 32'h7FBD);
		wr(SEL_MOVE, 32'h80000000, 1'h1);
		wr(SEL_MOVE, 32'h7FFFFFFF, 1'h0);
		wr(SEL_MOVE, 32'h80000001, 1'h0);
		rd(SEL_MOVE, 32'h80000001);
		wr(SEL_LIMIT, 32'h0, 1'h1);
		wr(SEL_LIMIT, 32'h4, 1'h1);
		$display("test 2 done");
		step_pin = 1'h0;
		for (int s = 1; s <= 3; s++) begin
			wr(SEL_LIMIT, 32'(s), 1'h0);
			wt(4);
			chk({cw_inh, ccw_inh, alarm}, lim_exp[s-1]);
		end
		chk({gp, lim_own}, 3'h4);
		$display("test 3 done");
		wr(SEL_LIMIT, 32'h2, 1'h0);
		foreach (modes[i]) begin
			mode = modes[i];
			wt(4);
			chk({cw_inh, ccw_inh, alarm}, 3'h0);
		end
		mode = 5'h0A;
		wt(4);
		chk({cw_inh, ccw_inh}, 2'h1);
		mode = 5'h13;
		wt(4);
		chk({cw_inh, ccw_inh}, 2'h1);
		$display("test 4 done");
		wr(SEL_JOG, 32'h1, 1'h0);
		rd(SEL_LIMIT, 32'(LIM_OFF));
		chk({jog_own, lim_own}, 2'h2);
		wr(SEL_LIMIT, 32'h1, 1'h0);
		wt(1);
		chk({jog_own, lim_own}, 2'h1);
		mode = 5'h07;
		wt(2);
		chk({jog_own, lim_own}, 2'h0);
		mode = 5'h00;
		$display("test 5 done");
		wr(SEL_MOVE, 32'hFFFFE0C0, 1'h0);
		mv(MV_REL);
		chk({setup.cw, setup.travel}, {1'h0, 32'h1F40});
		chk(setup.decel, 15'h7FBD);
		mv(MV_ABS);
		chk(setup.target, 32'hFFFFE0C0);
		mv(MV_JOG);
		chk(setup.cw, 1'h0);
		wr(SEL_CHG, 32'h64, 1'h0);
		mv(MV_MASK_SENSOR);
		move_active = 1'h1;
		sensor_in = 1'h0;
		travelled = 32'h63;
		wt(4);
		chk({chg_hit, sens_en}, 2'h0);
		travelled = 32'h64;
		wt(4);
		chk({chg_hit, sens_en}, 2'h3);
		wr(SEL_MOVE, 32'h10, 1'h0);
		mv(MV_REL);
		wt(4);
		chk({stop_acc, cw_inh}, 2'h3);
		wr(SEL_MOVE, 32'hFFFFFFF0, 1'h0);
		mv(MV_REL);
		wt(2);
		chk({stop_acc, cw_inh}, 2'h1);
		move_active = 1'h0;
		$display("test 6 done");
		nv_load = '{valid: 1'h1, chg: 32'h50, decel: 15'h7D,
			move: 32'hFFFFE0C0, limit: 2'h2};
		do_reset();
		rd(SEL_CHG, 32'h50);
		rd(SEL_DECEL, 32'h7D);
		rd(SEL_MOVE, 32'hFFFFE0C0);
		rd(SEL_LIMIT, 32'h2);
		$display("test 7 done");
		wrap_up();
	end
endmodule // test_move_param_limit_logic
